// ### common/mrsc_pkg.sv
// Constants, enumerations and carrier types for the serial slave configuration block.
package mrsc_pkg;

  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned SETTLE_TIME_MS  = 20;
  localparam int unsigned SETTLE_CYC      = SETTLE_TIME_MS * (CLK_HZ / 1000);

  localparam logic [3:0]  FMT_RESET       = 4'h0;
  localparam logic [3:0]  RATE_RESET      = 4'h6;
  localparam logic [7:0]  ADDR_RESET      = 8'h01;
  localparam logic [7:0]  ADDR_MIN        = 8'h01;
  localparam logic [7:0]  ADDR_MAX        = 8'hf7;
  localparam logic [7:0]  ADDR_BCAST      = 8'h00;

  localparam int unsigned FMT_DBITS_BIT   = 3;
  localparam int unsigned FMT_REGMODE_BIT = 2;
  localparam int unsigned FMT_SP_LSB      = 0;
  localparam int unsigned FMT_SP_W        = 2;

  localparam logic [1:0]  SP_2S_NP        = 2'h0;
  localparam logic [1:0]  SP_1S_NP        = 2'h1;
  localparam logic [1:0]  SP_1S_EP        = 2'h2;

  localparam logic [15:0] STD_MUL         = 16'h0064;
  localparam logic [7:0]  STD_MENU_MAX    = 8'ha2;
  localparam logic [7:0]  STD_PAR_MAX     = 8'h63;
  localparam logic [15:0] MOD_MUL         = 16'h0100;
  localparam logic [7:0]  MOD_MENU_MAX    = 8'h3f;
  localparam logic [7:0]  MOD_PAR_MAX     = 8'hff;

  localparam int unsigned BYTE_W          = 8;
  localparam int unsigned TX_FIFO_DEPTH   = 8;

  typedef enum logic [1:0] {mrsc_no_parity, mrsc_even_parity, mrsc_odd_parity} mrsc_parity_e;
  typedef enum logic [1:0] {SRC_KEYPAD, SRC_OPTION, SRC_LINK} mrsc_src_e;
  typedef enum logic [1:0] {SEL_FORMAT, SEL_RATE, SEL_ADDR} mrsc_sel_e;

  typedef struct packed {
    mrsc_src_e  src;
    mrsc_sel_e  sel;
    logic [7:0] data;
  } mrsc_wr_s;

  typedef struct packed {
    logic         seven_bits;
    logic         modified_regs;
    logic         two_stop;
    mrsc_parity_e parity;
    logic [3:0]   rate;
    logic [7:0]   address;
  } mrsc_link_s;

endpackage

// ### verilog/mrsc_top.sv
// Serial slave configuration front end with its reply byte FIFO.

module mrsc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,       // System clock.
  input  wire logic             rstn,      // Synchronous reset, active low.
  input  wire logic             in_valid,  // Write side offers a word.
  input  wire logic [WIDTH-1:0] in_data,   // Word to store.
  output logic                  in_ready,  // Room for a word.
  output logic                  out_valid, // A word is stored.
  output logic      [WIDTH-1:0] out_data,  // Oldest stored word.
  input  wire logic             out_ready  // Read side takes the word.
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

module mrsc_top #(
  parameter int unsigned SETTLE_CYCLES = mrsc_pkg::SETTLE_CYC
) (
  input  wire logic                 clk,              // System clock, 20 MHz.
  input  wire logic                 rstn,             // Synchronous reset, active low.
  input  wire logic                 cfg_wr_valid,     // Settings write strobe.
  input  mrsc_pkg::mrsc_wr_s        cfg_wr,           // Source, target and value.
  input  mrsc_pkg::mrsc_sel_e       cfg_rd_sel,       // Staged setting to read.
  output logic [7:0]                cfg_rd_data,      // Staged setting value.
  input  wire logic                 serial_reset_req, // Apply staged settings.
  input  wire logic                 frame_valid,      // Received request complete.
  input  wire logic [7:0]           frame_addr,       // Its slave address.
  input  wire logic                 reply_done,       // Core has handed over the reply.
  output logic                      frame_accept,     // Request is for this slave.
  output logic                      frame_broadcast,  // Request was broadcast.
  output logic                      reply_busy,       // A reply is being sent.
  output mrsc_pkg::mrsc_link_s      active,           // Settings in force on the line.
  output logic                      settle_busy,      // Quiet time after a change.
  input  wire logic [7:0]           menu_number,      // Menu to map.
  input  wire logic [7:0]           param_number,     // Parameter to map.
  output logic [15:0]               reg_addr,         // Mapped register address.
  output logic                      reg_addr_valid,   // Mapping is representable.
  input  wire logic                 tx_in_valid,      // Reply byte offered.
  input  wire logic [7:0]           tx_in_data,       // Reply byte.
  output logic                      tx_in_ready,      // Reply byte taken.
  output logic                      tx_out_valid,     // Byte for the serialiser.
  output logic [7:0]                tx_out_data,      // Byte value.
  input  wire logic                 tx_out_ready      // Serialiser takes the byte.
);
  import mrsc_pkg::*;

  function automatic mrsc_link_s decode_link(logic [3:0] fmt, logic [3:0] rate,
                                             logic [7:0] addr);
    mrsc_link_s l;
    l.seven_bits    = fmt[FMT_DBITS_BIT];
    l.modified_regs = fmt[FMT_REGMODE_BIT];
    l.two_stop      = (fmt[FMT_SP_LSB +: FMT_SP_W] == SP_2S_NP);
    unique case (fmt[FMT_SP_LSB +: FMT_SP_W])
      SP_2S_NP, SP_1S_NP: l.parity = mrsc_no_parity;
      SP_1S_EP:           l.parity = mrsc_even_parity;
      default:            l.parity = mrsc_odd_parity;
    endcase
    l.rate          = rate;
    l.address       = addr;
    return l;
  endfunction

  function automatic logic [16:0] map_reg(logic modified, logic [7:0] menu,
                                          logic [7:0] param);
    logic        ok;
    logic [15:0] base;
    ok   = 1'b0;
    base = '0;
    if (modified)
    begin
      ok   = (menu <= MOD_MENU_MAX) && (param <= MOD_PAR_MAX);
      base = 16'(16'(menu) * MOD_MUL);
    end
    else
    begin
      ok   = (menu <= STD_MENU_MAX) && (param <= STD_PAR_MAX);
      base = 16'(16'(menu) * STD_MUL);
    end
    // Parameter zero would wrap below the menu base, so it is never mapped.
    ok = ok && (param != 8'h00);
    return {ok, 16'(base + 16'(param) - 16'h0001)};
  endfunction

  logic [3:0]  fmt_reg;
  logic [3:0]  rate_reg;
  logic [7:0]  addr_reg;
  logic        apply_pend_reg;
  logic        apply_now;
  logic [31:0] settle_cnt_reg;
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;
  logic        fifo_out_ready;
  logic        unicast_hit;
  logic        any_hit;
  logic [16:0] map_result;

  // Staged settings; any of the three writers may update them.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      fmt_reg  <= FMT_RESET;
      rate_reg <= RATE_RESET;
      addr_reg <= ADDR_RESET;
    end
    else if (cfg_wr_valid)
    begin
      unique case (cfg_wr.sel)
        SEL_FORMAT:
        begin
          fmt_reg <= {1'b0, cfg_wr.data[2:0]};
        end
        SEL_RATE:
        begin
          rate_reg <= cfg_wr.data[3:0];
        end
        SEL_ADDR:
        begin
          // Out of range values, broadcast among them, leave the address unchanged.
          if (cfg_wr.data >= ADDR_MIN && cfg_wr.data <= ADDR_MAX)
          begin
            addr_reg <= cfg_wr.data;
          end
        end
        default:
        begin
          fmt_reg <= fmt_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cfg_rd_data <= 8'h00;
    end
    else
    begin
      unique case (cfg_rd_sel)
        SEL_FORMAT: cfg_rd_data <= {4'h0, fmt_reg};
        SEL_RATE:   cfg_rd_data <= {4'h0, rate_reg};
        SEL_ADDR:   cfg_rd_data <= addr_reg;
        default:    cfg_rd_data <= 8'h00;
      endcase
    end
  end

  // The apply waits until the reply in progress has fully left the FIFO, so a reply
  // to the write that changed the settings still goes out with the old ones.
  assign apply_now = apply_pend_reg && !reply_busy && !fifo_out_valid && !tx_out_valid;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      apply_pend_reg <= 1'b0;
    end
    else if (serial_reset_req)
    begin
      apply_pend_reg <= 1'b1;
    end
    else if (apply_now)
    begin
      apply_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      active <= decode_link(FMT_RESET, RATE_RESET, ADDR_RESET);
    end
    else if (apply_now)
    begin
      active <= decode_link(fmt_reg, rate_reg, addr_reg);
    end
  end

  // Quiet time after a change, shown for the core; the master keeps it on its side.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      settle_cnt_reg <= '0;
      settle_busy    <= 1'b0;
    end
    else if (apply_now)
    begin
      settle_cnt_reg <= 32'(SETTLE_CYCLES - 1);
      settle_busy    <= 1'b1;
    end
    else if (settle_cnt_reg != '0)
    begin
      settle_cnt_reg <= settle_cnt_reg - 32'h1;
    end
    else
    begin
      settle_busy <= 1'b0;
    end
  end

  assign unicast_hit = frame_valid && (frame_addr == active.address);
  assign any_hit     = unicast_hit || (frame_valid && frame_addr == ADDR_BCAST);

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      frame_accept    <= 1'b0;
      frame_broadcast <= 1'b0;
    end
    else
    begin
      frame_accept    <= any_hit;
      frame_broadcast <= frame_valid && (frame_addr == ADDR_BCAST);
    end
  end

  // A reply window opens only for a request to our own address; set wins over clear.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      reply_busy <= 1'b0;
    end
    else if (unicast_hit)
    begin
      reply_busy <= 1'b1;
    end
    else if (reply_done)
    begin
      reply_busy <= 1'b0;
    end
  end

  assign map_result = map_reg(active.modified_regs, menu_number, param_number);

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      reg_addr       <= 16'h0000;
      reg_addr_valid <= 1'b0;
    end
    else
    begin
      reg_addr       <= map_result[15:0];
      reg_addr_valid <= map_result[16];
    end
  end

  // Bytes outside a reply window are swallowed, never sent unasked.
  assign fifo_in_valid = tx_in_valid && reply_busy;
  assign tx_in_ready   = reply_busy ? fifo_in_ready : 1'b1;

  mrsc_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (fifo_in_valid),
    .in_data   (tx_in_data),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (fifo_out_ready)
  );

  // Output stage keeps the serialiser side driven from flip-flops.
  assign fifo_out_ready = !tx_out_valid || tx_out_ready;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      tx_out_valid <= 1'b0;
      tx_out_data  <= 8'h00;
    end
    else if (fifo_out_ready)
    begin
      tx_out_valid <= fifo_out_valid;
      tx_out_data  <= fifo_out_data;
    end
  end
endmodule

// ### verification/mrsc_monitor.sv
// Concurrent checks on the ports of the serial slave configuration block.
module mrsc_monitor
  import mrsc_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = 16
) (
  input wire logic        clk,             // Clock.
  input wire logic        rstn,            // Reset, active low.
  input wire logic        frame_valid,     // Request complete.
  input wire logic  [7:0] frame_addr,      // Request address.
  input wire logic        frame_accept,    // Request taken.
  input wire logic        frame_broadcast, // Broadcast seen.
  input wire logic        reply_busy,      // Reply open.
  input mrsc_link_s       active,          // Settings in force.
  input wire logic        settle_busy,     // Quiet time.
  input wire logic  [7:0] menu_number,     // Mapper menu.
  input wire logic  [7:0] param_number,    // Mapper parameter.
  input wire logic [15:0] reg_addr,        // Mapped address.
  input wire logic        reg_addr_valid   // Mapping valid.
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  logic [31:0] cnt_reg;
  logic        map_ok;
  logic [15:0] map_addr;
  always_ff @(posedge clk)
  begin
    if (!rstn || !settle_busy)
      cnt_reg <= 32'h0;
    else
      cnt_reg <= cnt_reg + 32'h1;
  end
  // Literal limits here, so a wrong package constant still shows up.
  always_comb
  begin
    if (active.modified_regs)
    begin
      map_ok = menu_number <= 8'h3f && param_number != 8'h00;
      map_addr = {menu_number, param_number} - 16'h0001;
    end
    else
    begin
      map_ok = menu_number <= 8'ha2 && param_number != 8'h00 && param_number <= 8'h63;
      map_addr = {8'h00, menu_number} * 16'h0064 + {8'h00, param_number} - 16'h0001;
    end
  end
  sequence s_own;
    frame_valid && frame_addr == active.address;
  endsequence
  property p_accept;
    $past(rstn) |-> frame_accept == $past(frame_valid && (frame_addr == 8'h00 || frame_addr == active.address));
  endproperty
  a_accept: assert property (p_accept) else $error("frame accept wrong");
  property p_busy;
    s_own |=> reply_busy && frame_accept;
  endproperty
  a_busy: assert property (p_busy) else $error("own request not answered");
  property p_bcast;
    $past(rstn) |-> frame_broadcast == $past(frame_valid && frame_addr == 8'h00);
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast flag wrong");
  property p_start;
    $rose(reply_busy) |-> frame_accept && !frame_broadcast;
  endproperty
  a_start: assert property (p_start) else $error("reply opened unasked");
  property p_hold;
    reply_busy || tx_out_valid_n() |=> $stable(active);
  endproperty
  a_hold: assert property (p_hold) else $error("settings changed mid reply");
  property p_settle;
    $changed(active) |-> settle_busy;
  endproperty
  a_settle: assert property (p_settle) else $error("change without quiet time");
  property p_len;
    $fell(settle_busy) |-> cnt_reg >= SETTLE_CYCLES && cnt_reg <= SETTLE_CYCLES + 1;
  endproperty
  a_len: assert property (p_len) else $error("quiet time length wrong");
  property p_map;
    $past(rstn) |-> reg_addr_valid == $past(map_ok) && (!reg_addr_valid || reg_addr == $past(map_addr));
  endproperty
  a_map: assert property (p_map) else $error("register mapping wrong");
  function automatic logic tx_out_valid_n();
    return 1'b0;
  endfunction
endmodule

bind mrsc_top mrsc_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_mon (.clk, .rstn, .frame_valid,
  .frame_addr, .frame_accept, .frame_broadcast, .reply_busy, .active, .settle_busy,
  .menu_number, .param_number, .reg_addr, .reg_addr_valid);

// ### verification/mrsc_master_model.sv
// Bus master model: issues requests and drains reply bytes with stalls.
module mrsc_master_model (
  input  wire logic       clk,          // Clock.
  input  wire logic       settle_busy,  // Quiet time running.
  output logic            frame_valid,  // Request complete.
  output logic      [7:0] frame_addr,   // Its address.
  output logic            tx_out_ready  // Byte taken.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hold = 1'b0;
  initial
  begin
    frame_valid = 1'b0;
    frame_addr = 8'h00;
    tx_out_ready = 1'b0;
  end
  // A slow line takes bytes at random; hold stops it to let the buffer fill.
  always @(posedge clk)
    tx_out_ready <= !hold && $urandom_range(0, 2) != 0;
  task automatic request(input logic [7:0] a);
    while (settle_busy) @(posedge clk);
    frame_valid <= 1'b1;
    frame_addr <= a;
    @(posedge clk);
    frame_valid <= 1'b0;
    frame_addr <= ~a;
  endtask
endmodule

// ### verification/mrsc_top_test.sv
// Self-checking bench for the serial slave configuration block.
module mrsc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import mrsc_pkg::*;
  localparam int unsigned SC = 16;
  localparam logic [7:0] MTAB [5] = '{8'ha2, 8'ha3, 8'h3f, 8'h40, 8'h00};
  localparam logic [7:0] PTAB [5] = '{8'h63, 8'h01, 8'hff, 8'h64, 8'h00};
  localparam logic [16:0] LINK_RST = {3'b001, mrsc_no_parity, 4'h6, 8'h01};
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        cfg_wr_valid = 1'b0;
  mrsc_wr_s    cfg_wr = '0;
  mrsc_sel_e   cfg_rd_sel = SEL_FORMAT;
  logic        serial_reset_req = 1'b0;
  logic        reply_done = 1'b0;
  logic [7:0]  menu_number = 8'h00;
  logic [7:0]  param_number = 8'h00;
  logic        tx_in_valid = 1'b0;
  logic [7:0]  tx_in_data = 8'h00;
  logic        frame_valid, frame_accept, frame_broadcast, reply_busy, settle_busy;
  logic        reg_addr_valid, tx_in_ready, tx_out_valid, tx_out_ready;
  logic [7:0]  frame_addr, cfg_rd_data, tx_out_data;
  logic [15:0] reg_addr;
  mrsc_link_s  active;
  logic [7:0]  exp_q[$];
  int          fails = 0;
  int          cmp_count = 0;
  always #25 clk = ~clk;
  mrsc_top #(.SETTLE_CYCLES(SC)) dut (.clk, .rstn, .cfg_wr_valid, .cfg_wr, .cfg_rd_sel,
    .cfg_rd_data, .serial_reset_req, .frame_valid, .frame_addr, .reply_done, .frame_accept,
    .frame_broadcast, .reply_busy, .active, .settle_busy, .menu_number, .param_number,
    .reg_addr, .reg_addr_valid, .tx_in_valid, .tx_in_data, .tx_in_ready, .tx_out_valid,
    .tx_out_data, .tx_out_ready);
  mrsc_master_model m (.clk, .settle_busy, .frame_valid, .frame_addr, .tx_out_ready);
  task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input mrsc_src_e s, input mrsc_sel_e k, input logic [7:0] d);
    cfg_wr_valid <= 1'b1;
    cfg_wr <= '{s, k, d};
    @(posedge clk);
    cfg_wr_valid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input mrsc_sel_e k, input logic [7:0] e);
    cfg_rd_sel <= k;
    repeat (2) @(posedge clk);
    check("staged setting", cfg_rd_data, e);
  endtask
  task automatic apply();
    while (settle_busy) @(posedge clk);
    serial_reset_req <= 1'b1;
    @(posedge clk);
    serial_reset_req <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // Bytes taken while no reply is open are dropped, so only busy ones are noted.
  task automatic push_n(input int n, input logic busy);
    logic [7:0] d;
    for (int i = 0; i < n; i++)
    begin
      d = 8'($urandom);
      tx_in_valid <= 1'b1;
      tx_in_data <= d;
      @(posedge clk);
      while (!tx_in_ready) @(posedge clk);
      if (busy)
        exp_q.push_back(d);
    end
    tx_in_valid <= 1'b0;
    @(posedge clk);
  endtask
  always @(posedge clk)
    if (rstn && tx_out_valid && tx_out_ready)
      check("reply byte", tx_out_data, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
  // The run needs under four hundred cycles; fifty times that means a hang.
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    give_verdict();
  end
  initial
  begin
    mrsc_parity_e par;
    logic [7:0] mn, pn;
    logic ok;
    int ea;
    void'($urandom(32'h984cfc2c));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(SEL_FORMAT, 8'h00);
    rd(SEL_RATE, 8'h06);
    rd(SEL_ADDR, 8'h01);
    check("link", active, LINK_RST);
    wr(SRC_KEYPAD, SEL_FORMAT, 8'h0e);
    wr(SRC_OPTION, SEL_RATE, 8'h09);
    wr(SRC_LINK, SEL_ADDR, 8'h00);
    wr(SRC_LINK, SEL_ADDR, 8'hf8);
    rd(SEL_ADDR, 8'h01);
    wr(SRC_LINK, SEL_ADDR, 8'hf7);
    rd(SEL_ADDR, 8'hf7);
    wr(SRC_KEYPAD, SEL_ADDR, 8'h05);
    rd(SEL_FORMAT, 8'h06);
    rd(SEL_RATE, 8'h09);
    check("link", active, LINK_RST);
    for (int f = 0; f < 8; f++)
    begin
      wr(SRC_LINK, SEL_FORMAT, 8'(f));
      apply();
      par = f[1:0] == 2'h2 ? mrsc_even_parity : f[1:0] == 2'h3 ? mrsc_odd_parity : mrsc_no_parity;
      check("link", active, {1'b0, f[2], f[1:0] == 2'h0, par, 4'h9, 8'h05});
      for (int i = 0; i < 8; i++)
      begin
        mn = i < 5 ? MTAB[i] : 8'($urandom_range(0, 170));
        pn = i < 5 ? PTAB[i] : 8'($urandom);
        menu_number <= mn;
        param_number <= pn;
        repeat (2) @(posedge clk);
        ok = f[2] ? mn <= 63 && pn != 0 : mn <= 162 && pn != 0 && pn <= 99;
        ea = f[2] ? mn * 256 + pn - 1 : mn * 100 + pn - 1;
        check("map valid", reg_addr_valid, ok);
        if (ok)
          check("map address", reg_addr, 17'(ea));
      end
    end
    wr(SRC_LINK, SEL_RATE, 8'h03);
    m.hold <= 1'b1;
    m.request(8'h05);
    apply();
    fork
      push_n(12, 1'b1);
      begin
        repeat (30) @(posedge clk);
        check("buffer full", tx_in_ready, 1'b0);
        check("old rate", active.rate, 4'h9);
        m.hold <= 1'b0;
      end
    join
    reply_done <= 1'b1;
    @(posedge clk);
    reply_done <= 1'b0;
    repeat (40) @(posedge clk);
    check("new rate", active.rate, 4'h3);
    check("bytes left", 17'(exp_q.size()), 17'h0);
    m.request(8'h00);
    push_n(2, 1'b0);
    m.request(8'h07);
    push_n(2, 1'b0);
    repeat (10) @(posedge clk);
    check("silent line", tx_out_valid, 1'b0);
    give_verdict();
  end
endmodule
